// ===== pkg/pct_pkg.sv
package pct_pkg;
    localparam int          CNT_W       = 8;
    localparam logic [7:0]  CNT_RST     = 8'h00;
    localparam logic [7:0]  PER_RST     = 8'h00;
    localparam logic [7:0]  DTY_RST     = 8'h00;
    localparam int          NUM_CH      = 8;
    // Channels whose clock pair is B/SB; the rest use A/SA
    localparam logic [7:0]  CLK_B_MAP   = 8'hcc;
endpackage

// ===== logic/pct_clk_sel.sv
`timescale 1ns/10ps
module pct_clk_sel #(
    parameter int NUM_CH = 8
) (
    input  wire logic              clk_a_tick_i,
    input  wire logic              clk_sa_tick_i,
    input  wire logic              clk_b_tick_i,
    input  wire logic              clk_sb_tick_i,
    input  wire logic [NUM_CH-1:0] clock_choice_bit_i,
    output wire logic [NUM_CH-1:0] ch_tick_o
);
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            wire logic use_b;
            assign use_b = pct_pkg::CLK_B_MAP[g % 8];
            // Prescaled or scaled clock per channel, from its group's pair
            assign ch_tick_o[g] = use_b ?
                (clock_choice_bit_i[g] ? clk_sb_tick_i : clk_b_tick_i) :
                (clock_choice_bit_i[g] ? clk_sa_tick_i : clk_a_tick_i);
        end
    endgenerate
endmodule

// ===== logic/pct_channel.sv
`timescale 1ns/10ps
module pct_channel #(
    parameter int CNT_W = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             tick_i,
    input  wire logic             channel_enable_bit_i,
    input  wire logic             start_polarity_bit_i,
    input  wire logic             center_align_bit_i,
    input  wire logic             per_wr_i,
    input  wire logic             dty_wr_i,
    input  wire logic             cnt_wr_i,
    input  wire logic [CNT_W-1:0] wdata_i,
    output wire logic [CNT_W-1:0] channel_counter_o,
    output wire logic [CNT_W-1:0] period_value_o,
    output wire logic [CNT_W-1:0] duty_value_o,
    output wire logic             pwm_o
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] per_buf_ff;
    logic [CNT_W-1:0] dty_buf_ff;
    logic [CNT_W-1:0] per_ff;
    logic [CNT_W-1:0] dty_ff;
    logic             down_ff;
    logic             flop_ff;
    logic             run_ff;
    logic             zero_rst_ff;
    logic             pout_ff;

    wire logic [CNT_W-1:0] nxt_per_buf;
    wire logic [CNT_W-1:0] nxt_dty_buf;
    wire logic [CNT_W-1:0] cnt_step;
    wire logic             step;
    wire logic             per_match;
    wire logic             dty_match;
    wire logic             left_end;
    wire logic             ctr_up_end;
    wire logic             ctr_low_end;
    wire logic             load;
    wire logic             out_raw;

    assign nxt_per_buf = per_wr_i ? wdata_i : per_buf_ff;
    assign nxt_dty_buf = dty_wr_i ? wdata_i : dty_buf_ff;
    // Gated clock: only whole selected-clock ticks reach the counter
    assign step        = run_ff & channel_enable_bit_i & tick_i &
                         ~cnt_wr_i;
    assign per_match   = (cnt_ff == per_ff);
    // Count the counter moves to on this tick
    assign cnt_step    = (down_ff | ctr_up_end) ? cnt_ff - 8'h01 :
                                                  cnt_ff + 8'h01;
    // Toggle as the counter arrives on the duty count
    assign dty_match   = (cnt_step == dty_ff);
    assign left_end    = ~center_align_bit_i &
                         (cnt_ff + 8'h01 >= per_ff);
    assign ctr_up_end  = center_align_bit_i & ~down_ff & per_match;
    assign ctr_low_end = center_align_bit_i & down_ff &
                         (cnt_ff == 8'h01);
    assign load        = (step & (left_end | ctr_low_end)) | cnt_wr_i |
                         ~channel_enable_bit_i;
    // Output mux on flip-flop Q or not-Q
    assign out_raw     = start_polarity_bit_i ? ~flop_ff : flop_ff;
    assign channel_counter_o = cnt_ff;
    assign period_value_o    = per_buf_ff;
    assign duty_value_o      = dty_buf_ff;
    assign pwm_o             = pout_ff;

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            per_buf_ff <= pct_pkg::PER_RST;
            dty_buf_ff <= pct_pkg::DTY_RST;
        end
        else
        begin
            per_buf_ff <= nxt_per_buf;
            dty_buf_ff <= nxt_dty_buf;
        end
    end

    // Active latches follow writes directly while disabled
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            per_ff <= pct_pkg::PER_RST;
            dty_ff <= pct_pkg::DTY_RST;
        end
        else if (load)
        begin
            per_ff <= nxt_per_buf;
            dty_ff <= nxt_dty_buf;
        end
    end

    // Enable synchronised to the selected clock edge
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            run_ff <= 1'b0;
        else if (!channel_enable_bit_i)
            run_ff <= 1'b0;
        else if (tick_i)
            run_ff <= 1'b1;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            zero_rst_ff <= 1'b0;
        else if (per_wr_i && !channel_enable_bit_i && wdata_i == 8'h00)
            zero_rst_ff <= 1'b1;
        else if (tick_i || cnt_wr_i)
            zero_rst_ff <= 1'b0;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cnt_ff  <= pct_pkg::CNT_RST;
            down_ff <= 1'b0;
            flop_ff <= 1'b0;
        end
        else if (cnt_wr_i)
        begin
            cnt_ff  <= pct_pkg::CNT_RST;
            down_ff <= 1'b0;
            flop_ff <= 1'b0;
        end
        else if (zero_rst_ff && tick_i)
            cnt_ff  <= pct_pkg::CNT_RST;
        else if (step)
        begin
            if (dty_match)
                flop_ff <= ~flop_ff;
            if (left_end)
            begin
                cnt_ff  <= pct_pkg::CNT_RST;
                flop_ff <= 1'b0;
            end
            else if (ctr_up_end)
            begin
                down_ff <= 1'b1;
                cnt_ff  <= cnt_ff - 8'h01;
            end
            else if (ctr_low_end)
            begin
                down_ff <= 1'b0;
                cnt_ff  <= pct_pkg::CNT_RST;
                flop_ff <= 1'b0;
            end
            else if (down_ff)
                cnt_ff  <= cnt_ff - 8'h01;
            else
                cnt_ff  <= cnt_ff + 8'h01;
        end
    end

    // Boundary cases: no period, duty at or above period, or zero duty
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pout_ff <= 1'b0;
        else if (per_ff == 8'h00)
            pout_ff <= start_polarity_bit_i;
        else if (dty_ff >= per_ff)
            pout_ff <= start_polarity_bit_i;
        else if (dty_ff == 8'h00)
            pout_ff <= ~start_polarity_bit_i;
        else
            pout_ff <= out_raw;
    end

    a_stop_holds: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        (!channel_enable_bit_i && !cnt_wr_i && !zero_rst_ff)
        |=> $stable(cnt_ff))
        else $error("counter moved while off");
    a_wr_clears: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        cnt_wr_i |=> (cnt_ff == 8'h00) && !down_ff)
        else $error("counter write did not clear");
    a_left_upper: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        (step && left_end) |=> cnt_ff == 8'h00)
        else $error("left counter did not wrap");
    a_off_latch: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        (!channel_enable_bit_i && per_wr_i)
        |=> per_ff == $past(wdata_i))
        else $error("latch not direct");
    a_on_buffer: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        (channel_enable_bit_i && !load) |=> $stable(per_ff))
        else $error("active period changed mid cycle");
    a_run_sync: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        $rose(run_ff) |-> $past(tick_i))
        else $error("enable not tick aligned");
    a_count_step: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        (step && !center_align_bit_i && !left_end && !zero_rst_ff)
        |=> cnt_ff == $past(cnt_ff) + 8'h01)
        else $error("counter did not step");
    a_duty_tog: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        (step && dty_match && !left_end && !ctr_low_end
        && !zero_rst_ff) |=> flop_ff != $past(flop_ff))
        else $error("duty match did not toggle");
    a_no_run_off: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        !channel_enable_bit_i |=> !run_ff)
        else $error("run stayed on");
    a_center_turn: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        (step && ctr_up_end) |=> down_ff)
        else $error("center count did not turn");
    a_center_low: assert property (
        @(posedge core_clk_i) disable iff (!resetn_i)
        (step && ctr_low_end) |=> (cnt_ff == 8'h00) && !down_ff)
        else $error("center count did not return up");
endmodule

// ===== logic/pct_timer.sv
// Notes on behaviour
// - Enable acts on next selected clock tick
// - Disabled channel counter does not advance
// - Polarity sets starting output level
// - Period, duty buffered until load points
// - Disabled writes go straight to latches
// - Per-channel 8-bit up/down counter
// - Duty match toggles output flip-flop
// - Counter reads have no side effects
// - Counter write clears, loads, sets polarity
// - Disable freezes count; enable resumes
// - Zero period while disabled resets counter
// - Running counter write restarts period
// - Counter clears at period end
// - Alignment bit clear gives left-aligned
// - Left-aligned counts zero to period minus one
// - Period match resets, loads buffers
// - Frequency is clock over period; center-aligned halves it
// - Center-aligned counts up then down
// - Clock pair chosen by channel group
`timescale 1ns/10ps
module pct_timer #(
    parameter int NUM_CH = 8,
    parameter int CNT_W  = 8
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    resetn_i,
    input  wire logic                    clk_a_tick_i,
    input  wire logic                    clk_sa_tick_i,
    input  wire logic                    clk_b_tick_i,
    input  wire logic                    clk_sb_tick_i,
    input  wire logic [NUM_CH-1:0]       channel_enable_bit_i,
    input  wire logic [NUM_CH-1:0]       polarity_register_i,
    input  wire logic [NUM_CH-1:0]       alignment_select_register_i,
    input  wire logic [NUM_CH-1:0]       clock_choice_bit_i,
    input  wire logic [NUM_CH-1:0]       per_wr_i,
    input  wire logic [NUM_CH-1:0]       dty_wr_i,
    input  wire logic [NUM_CH-1:0]       cnt_wr_i,
    input  wire logic [CNT_W-1:0]        wdata_i,
    output wire logic [NUM_CH*CNT_W-1:0] channel_counter_o,
    output wire logic [NUM_CH*CNT_W-1:0] period_value_o,
    output wire logic [NUM_CH*CNT_W-1:0] duty_value_o,
    output wire logic [NUM_CH-1:0]       pwm_o
);
    wire logic [NUM_CH-1:0] ch_tick;

    pct_clk_sel #(
        .NUM_CH (NUM_CH)
    ) u_sel (
        .clk_a_tick_i       (clk_a_tick_i),
        .clk_sa_tick_i      (clk_sa_tick_i),
        .clk_b_tick_i       (clk_b_tick_i),
        .clk_sb_tick_i      (clk_sb_tick_i),
        .clock_choice_bit_i (clock_choice_bit_i),
        .ch_tick_o          (ch_tick)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            // Each channel takes its own control bits
            pct_channel #(
                .CNT_W (CNT_W)
            ) u_ch (
                .core_clk_i           (core_clk_i),
                .resetn_i             (resetn_i),
                .tick_i               (ch_tick[g]),
                .channel_enable_bit_i (channel_enable_bit_i[g]),
                .start_polarity_bit_i (polarity_register_i[g]),
                .center_align_bit_i   (alignment_select_register_i[g]),
                .per_wr_i             (per_wr_i[g]),
                .dty_wr_i             (dty_wr_i[g]),
                .cnt_wr_i             (cnt_wr_i[g]),
                .wdata_i              (wdata_i),
                .channel_counter_o    (channel_counter_o[g*CNT_W +: CNT_W]),
                .period_value_o       (period_value_o[g*CNT_W +: CNT_W]),
                .duty_value_o         (duty_value_o[g*CNT_W +: CNT_W]),
                .pwm_o                (pwm_o[g])
            );
        end
    endgenerate
endmodule

// ===== tb/pct_timer_tb_top.sv
`timescale 1ns/10ps
module pct_timer_tb_top;
    logic        core_clk_i = 1'b0;
    logic        resetn_i   = 1'b0;
    // Tick pulses, bit 0 = A, 1 = SA, 2 = B, 3 = SB
    logic [3:0]  tick       = 4'h0;
    logic [7:0]  enable     = 8'h00;
    logic [7:0]  pol        = 8'h00;
    logic [7:0]  align      = 8'h00;
    logic [7:0]  choice     = 8'h04;
    // Write select, bit 0 = period, 1 = duty, 2 = counter
    logic [2:0]  wsel       = 3'h0;
    logic [7:0]  wdata      = 8'h00;
    wire  logic [63:0] cnt_o;
    wire  logic [63:0] per_o;
    wire  logic [63:0] dty_o;
    wire  logic [7:0]  pwm;
    wire  logic [7:0]  per_wr   = wsel[0] ? 8'h05 : 8'h00;
    wire  logic [7:0]  dty_wr   = wsel[1] ? 8'h05 : 8'h00;
    wire  logic [7:0]  cnt_wr   = wsel[2] ? 8'h05 : 8'h00;
    int          bad_count  = 0;
    int          n_tests    = 0;
    int          cycles     = 0;

    pct_timer pct_timer_inst (
        .core_clk_i                  (core_clk_i),
        .resetn_i                    (resetn_i),
        .clk_a_tick_i                (tick[0]),
        .clk_sa_tick_i               (tick[1]),
        .clk_b_tick_i                (tick[2]),
        .clk_sb_tick_i               (tick[3]),
        .channel_enable_bit_i        (enable),
        .polarity_register_i         (pol),
        .alignment_select_register_i (align),
        .clock_choice_bit_i          (choice),
        .per_wr_i                    (per_wr),
        .dty_wr_i                    (dty_wr),
        .cnt_wr_i                    (cnt_wr),
        .wdata_i                     (wdata),
        .channel_counter_o           (cnt_o),
        .period_value_o              (per_o),
        .duty_value_o                (dty_o),
        .pwm_o                       (pwm)
    );

    always #12.5 core_clk_i = ~core_clk_i;

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count = bad_count + 1;
            stop_test();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic settle;
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    task automatic wr(input logic [2:0] sel, input logic [7:0] v);
        @(posedge core_clk_i);
        wsel  <= sel;
        wdata <= v;
        @(posedge core_clk_i);
        wsel  <= 3'h0;
        settle();
    endtask

    task automatic tk(input logic [3:0] which);
        @(posedge core_clk_i);
        tick <= which;
        @(posedge core_clk_i);
        tick <= 4'h0;
        settle();
    endtask

    // Channel 0 runs from A, channel 2 from SB
    task automatic chk_cnt(input logic [7:0] exp);
        chk("counter ch0", exp, cnt_o[7:0]);
        chk("counter ch2", exp, cnt_o[23:16]);
    endtask

    task automatic chk_ch(input logic [7:0] exp, input logic exp_pwm);
        chk_cnt(exp);
        chk("pwm ch0", {7'h00, exp_pwm}, {7'h00, pwm[0]});
        chk("pwm ch2", {7'h00, exp_pwm}, {7'h00, pwm[2]});
    endtask

    initial
    begin
        logic [7:0] e;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        @(negedge core_clk_i);
        chk_ch(8'h00, 1'b0);
        chk("period reset", 8'h00, per_o[7:0]);
        wr(3'h1, 8'h04);
        chk("period ch0", 8'h04, per_o[7:0]);
        chk("period ch2", 8'h04, per_o[23:16]);
        wr(3'h2, 8'h01);
        chk("duty ch0", 8'h01, dty_o[7:0]);
        wr(3'h4, 8'h5a);
        chk_cnt(8'h00);
        tk(4'hf);
        chk_cnt(8'h00);
        @(posedge core_clk_i);
        enable <= 8'h05;
        tk(4'h9);
        chk_ch(8'h00, 1'b0);
        tk(4'h6);
        chk_ch(8'h00, 1'b0);
        for (int i = 1; i <= 8; i++)
        begin
            tk(4'h9);
            e = 8'(i % 4);
            chk_ch(e, e >= 8'h01);
        end
        tk(4'h9);
        tk(4'h9);
        wr(3'h1, 8'h06);
        chk("period buffer", 8'h06, per_o[7:0]);
        for (int i = 3; i <= 10; i++)
        begin
            tk(4'h9);
            e = (i == 3) ? 8'h03 : 8'((i - 4) % 6);
            chk_ch(e, e >= 8'h01);
        end
        tk(4'h9);
        tk(4'h9);
        @(posedge core_clk_i);
        enable <= 8'h00;
        tk(4'h9);
        tk(4'h9);
        chk_cnt(8'h02);
        @(posedge core_clk_i);
        enable <= 8'h05;
        tk(4'h9);
        chk_cnt(8'h02);
        tk(4'h9);
        chk_ch(8'h03, 1'b1);
        @(posedge core_clk_i);
        pol <= 8'h05;
        wr(3'h4, 8'hff);
        chk_ch(8'h00, 1'b1);
        tk(4'h9);
        chk_ch(8'h01, 1'b0);
        tk(4'h9);
        chk_ch(8'h02, 1'b0);
        @(posedge core_clk_i);
        enable <= 8'h00;
        wr(3'h1, 8'h00);
        chk("period zero", 8'h00, per_o[7:0]);
        tk(4'h9);
        chk_cnt(8'h00);
        // Center aligned, mode chosen while the channel is off
        @(posedge core_clk_i);
        pol   <= 8'h00;
        align <= 8'h05;
        wr(3'h1, 8'h04);
        wr(3'h4, 8'h00);
        chk_ch(8'h00, 1'b0);
        @(posedge core_clk_i);
        enable <= 8'h05;
        tk(4'h9);
        chk_ch(8'h00, 1'b0);
        for (int i = 1; i <= 10; i++)
        begin
            tk(4'h9);
            e = 8'((i % 8 > 4) ? 8 - i % 8 : i % 8);
            chk_ch(e, (i % 8 > 0) && (i % 8 < 7));
        end
        stop_test();
    end
endmodule
